// ### hw/ltr_pkg.sv
package ltr_pkg;

  // Clock and sampling
  localparam int SYS_CLK_HZ = 200_000_000;
  localparam int SAMPLE_RATE_HZ = 1000;
  localparam int SAMPLE_DIV_DEF = SYS_CLK_HZ / SAMPLE_RATE_HZ;
  localparam int RMS_WIN_DEF = 20;
  localparam int STEP_MS_DEF = RMS_WIN_DEF * 1000 / SAMPLE_RATE_HZ;
  localparam int TAU_MIN_DEF = 10;
  localparam int TAU_STEPS_DEF = TAU_MIN_DEF * 60_000 / STEP_MS_DEF;

  // Fixed point
  localparam int INV_SHIFT = 16;
  localparam logic [15:0] PCT_Q16 = 16'h028f;
  localparam int DIV_BITS = 48;

  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_AMB = 8'h04;
  localparam logic [7:0] REG_STARTUP = 8'h08;
  localparam logic [7:0] REG_ALARM = 8'h0c;
  localparam logic [7:0] REG_TRIP = 8'h10;
  localparam logic [7:0] REG_UNLOCK = 8'h14;
  localparam logic [7:0] REG_RATED_TEMP = 8'h18;
  localparam logic [7:0] REG_BASE_TEMP = 8'h1c;
  localparam logic [7:0] REG_REF_CURRENT = 8'h20;
  localparam logic [7:0] REG_TAU_STEPS = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h28;
  localparam logic [7:0] REG_TEMP = 8'h2c;
  localparam logic [7:0] REG_LEVEL = 8'h30;
  localparam logic [7:0] REG_RMS_A = 8'h34;
  localparam logic [7:0] REG_RMS_B = 8'h38;
  localparam logic [7:0] REG_RMS_C = 8'h3c;
  localparam logic [7:0] REG_IRQ_STS = 8'h40;
  localparam logic [7:0] REG_IRQ_MASK = 8'h44;

  // Field positions
  localparam int CTRL_AMB_SEL_BIT = 0;
  localparam int ST_ALARM_BIT = 0;
  localparam int ST_TRIP_BIT = 1;
  localparam int ST_UNLOCK_BIT = 2;
  localparam int ST_INIT_BIT = 3;

  // Reset values
  localparam logic [7:0] AMB_RST = 8'h19;
  localparam logic [7:0] STARTUP_RST = 8'h00;
  localparam logic [7:0] ALARM_RST = 8'h50;
  localparam logic [7:0] TRIP_RST = 8'h64;
  localparam logic [7:0] UNLOCK_RST = 8'h3c;
  localparam logic [7:0] RATED_TEMP_RST = 8'h64;
  localparam logic [7:0] BASE_TEMP_RST = 8'h19;
  localparam logic [15:0] REF_CURRENT_RST = 16'h1000;
  localparam logic [31:0] TAU_STEPS_RST = 32'(TAU_STEPS_DEF);

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SQRT,
    ST_RATIO,
    ST_DIV_RATIO,
    ST_STEP,
    ST_DIV_STEP,
    ST_TEMP
  } ltr_fsm_t;

endpackage : ltr_pkg

// ### hw/ltr_top.sv
// Notes on behaviour
// - A true RMS value is formed separately for each of the three phases.
// - Samples are requested and processed at 1 kHz, passing content below 500 Hz.
// - Only the largest of the three RMS values drives the thermal model.
// - Level becomes (1-dt/T) times old level plus dt/T times (I/Iref) squared.
// - Level is overtemperature as a fraction of the reference overtemperature.
// - Object temperature is overtemperature plus ambient temperature.
// - Each step compares the computed temperature against the threshold settings.
// - A control bit picks the measured sensor or the fixed ambient setting.
// - The first level is loaded from the startup setting, not from zero.
// - Alarm, trip and unlock outputs assert when temperature exceeds each threshold.
`timescale 1ns/1ps

module ltr_top import ltr_pkg::*; #(
  parameter int SAMPLE_DIV = SAMPLE_DIV_DEF,
  parameter int RMS_WIN = RMS_WIN_DEF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Sample stream
  output logic sample_tick,
  input wire logic sample_valid,
  input wire logic signed [15:0] phase_a_current_sample,
  input wire logic signed [15:0] phase_b_current_sample,
  input wire logic signed [15:0] phase_c_current_sample,
  // Ambient sensor
  input wire logic [7:0] ambient_sensor_temp,
  // Results
  output logic [15:0] phase_a_current_rms,
  output logic [15:0] phase_b_current_rms,
  output logic [15:0] phase_c_current_rms,
  output logic [15:0] max_current_rms,
  output logic [15:0] object_temp,
  output logic alarm_active,
  output logic trip_active,
  output logic unlock_above,
  output logic irq
);

  localparam int TICK_W = $clog2(SAMPLE_DIV);
  localparam int WIN_W = $clog2(RMS_WIN);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SAMPLE_DIV - 1);
  localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(RMS_WIN - 1);
  localparam logic [15:0] INV_WIN = 16'((2 ** INV_SHIFT + RMS_WIN / 2) / RMS_WIN);

  typedef struct packed {
    ltr_fsm_t fsm;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic [WIN_W-1:0] win_cnt;
    logic [2:0][36:0] acc;
    logic [2:0][36:0] sum;
    logic [2:0][15:0] rms;
    logic [1:0] ph;
    logic [3:0] bit_idx;
    logic [15:0] root;
    logic [47:0] num;
    logic [31:0] den;
    logic [32:0] rem;
    logic [5:0] div_cnt;
    logic neg;
    logic [15:0] imax;
    logic [31:0] ratio;
    logic [47:0] level;
    logic init_done;
    logic [15:0] temp;
    logic alarm;
    logic trip;
    logic unl;
    logic [7:0] amb_s1;
    logic [7:0] amb_s2;
    logic amb_sel;
    logic [7:0] amb_set;
    logic [7:0] startup;
    logic [7:0] alarm_thr;
    logic [7:0] trip_thr;
    logic [7:0] unlock_thr;
    logic [7:0] rated_temp;
    logic [7:0] base_temp;
    logic [15:0] ref_cur;
    logic [31:0] tau_steps;
    logic [2:0] irq_sts;
    logic [2:0] irq_mask;
    logic irq;
    logic [31:0] rdata;
  } ltr_state_t;

  localparam ltr_state_t RESET_STATE = '{
    fsm: ST_IDLE,
    amb_set: AMB_RST,
    startup: STARTUP_RST,
    alarm_thr: ALARM_RST,
    trip_thr: TRIP_RST,
    unlock_thr: UNLOCK_RST,
    rated_temp: RATED_TEMP_RST,
    base_temp: BASE_TEMP_RST,
    ref_cur: REF_CURRENT_RST,
    tau_steps: TAU_STEPS_RST,
    default: '0
  };

  ltr_state_t q;
  ltr_state_t d;

  logic [2:0][15:0] samp;
  logic [2:0][31:0] sq;
  logic [2:0][31:0] mean_sq;
  logic [15:0] trial;
  logic [31:0] trial_sq;
  logic [32:0] rem_sh;
  logic div_hit;
  logic [15:0] max_ab;
  logic [47:0] target;
  logic [47:0] level_base;
  logic [7:0] theta_n;
  logic [39:0] theta_prod;
  logic [7:0] amb_now;
  logic [24:0] temp_full;
  logic [15:0] temp_sat;
  logic [2:0] ev;
  logic [2:0] w1c;
  logic [31:0] status_word;

  assign samp[0] = phase_a_current_sample;
  assign samp[1] = phase_b_current_sample;
  assign samp[2] = phase_c_current_sample;

  // Per-phase square and mean square of the closed window
  for (genvar g = 0; g < 3; g++) begin : g_phase
    logic [52:0] scaled;
    assign sq[g] = 32'($signed(samp[g]) * $signed(samp[g]));
    assign scaled = 53'(q.sum[g] * INV_WIN);
    assign mean_sq[g] = scaled[47:16];
  end

  // Square root trial for all three phases and restoring divider step shared by both divisions
  assign trial = q.root | (16'h0001 << q.bit_idx);
  assign trial_sq = 32'(trial * trial);
  assign rem_sh = {q.rem[31:0], q.num[47]};
  assign div_hit = rem_sh >= {1'b0, q.den};

  // Larger of the phase a and b currents and the recursion target in Q32
  assign max_ab = (q.rms[0] > q.rms[1]) ? q.rms[0] : q.rms[1];
  assign target = {q.ratio, 16'h0000};

  // Startup level used once; product kept whole so large settings cannot wrap
  assign level_base = q.init_done ? q.level : {32'(q.startup) * 32'(PCT_Q16), 16'h0000};

  // Overtemperature from the rated rise, then ambient added and saturated
  assign theta_n = (q.rated_temp > q.base_temp) ? 8'(q.rated_temp - q.base_temp) : 8'h00;
  assign theta_prod = 40'(q.level[47:16] * theta_n);
  assign amb_now = q.amb_sel ? q.amb_s2 : q.amb_set;
  assign temp_full = 25'(theta_prod[39:16]) + 25'(amb_now);
  assign temp_sat = (temp_full[24:16] != 9'h000) ? 16'hffff : temp_full[15:0];
  assign status_word = {28'h0, q.init_done, q.unl, q.trip, q.alarm};

  // Next state of the whole block
  always_comb begin
    d = q;
    ev = '0;
    w1c = '0;
    d.tick = 1'b0;
    d.rdata = '0;
    d.amb_s1 = ambient_sensor_temp;
    d.amb_s2 = q.amb_s1;

    // Sample request every 1 ms
    if (q.tick_cnt == TICK_LAST) begin
      d.tick_cnt = '0;
      d.tick = 1'b1;
    end else begin
      d.tick_cnt = q.tick_cnt + 1'b1;
    end

    // Accumulate squares; close the window every RMS_WIN samples
    if (sample_valid) begin
      for (int p = 0; p < 3; p++) begin
        d.acc[p] = q.acc[p] + 37'(sq[p]);
      end
      if (q.win_cnt == WIN_LAST) begin
        for (int p = 0; p < 3; p++) begin
          d.sum[p] = q.acc[p] + 37'(sq[p]);
          d.acc[p] = '0;
        end
        d.win_cnt = '0;
        d.fsm = ST_SQRT;
        d.ph = 2'd0;
        d.bit_idx = 4'hf;
        d.root = '0;
      end else begin
        d.win_cnt = q.win_cnt + 1'b1;
      end
    end

    // Computation sequence, one new maximum per window
    case (q.fsm)
      ST_IDLE: begin
      end
      ST_SQRT: begin
        if (trial_sq <= mean_sq[q.ph]) begin
          d.root = trial;
        end
        if (q.bit_idx == 4'h0) begin
          d.rms[q.ph] = (trial_sq <= mean_sq[q.ph]) ? trial : q.root;
          d.root = '0;
          d.bit_idx = 4'hf;
          if (q.ph == 2'd2) begin
            d.fsm = ST_RATIO;
          end else begin
            d.ph = q.ph + 2'd1;
          end
        end else begin
          d.bit_idx = q.bit_idx - 4'h1;
        end
      end
      ST_RATIO: begin
        d.imax = (q.rms[2] > max_ab) ? q.rms[2] : max_ab;
        d.num = {32'(d.imax * d.imax), 16'h0000};
        d.den = 32'(q.ref_cur * q.ref_cur);
        d.rem = '0;
        d.div_cnt = 6'(DIV_BITS - 1);
        d.fsm = ST_DIV_RATIO;
      end
      ST_DIV_RATIO, ST_DIV_STEP: begin
        d.rem = div_hit ? 33'(rem_sh - {1'b0, q.den}) : rem_sh;
        d.num = {q.num[46:0], div_hit};
        if (q.div_cnt == 6'h00) begin
          if (q.fsm == ST_DIV_RATIO) begin
            d.ratio = (d.num[47:32] != 16'h0000) ? 32'hffffffff : d.num[31:0];
            d.fsm = ST_STEP;
          end else if (q.neg) begin
            d.level = q.level - d.num;
            d.fsm = ST_TEMP;
          end else begin
            d.level = q.level + d.num;
            d.fsm = ST_TEMP;
          end
        end else begin
          d.div_cnt = q.div_cnt - 6'h01;
        end
      end
      ST_STEP: begin
        // Level moves by (target - level) * dt/T, dt being one step
        d.level = level_base;
        d.init_done = 1'b1;
        d.neg = target < level_base;
        d.num = d.neg ? 48'(level_base - target) : 48'(target - level_base);
        d.den = q.tau_steps;
        d.rem = '0;
        d.div_cnt = 6'(DIV_BITS - 1);
        d.fsm = ST_DIV_STEP;
      end
      ST_TEMP: begin
        d.temp = temp_sat;
        d.alarm = temp_sat > 16'(q.alarm_thr);
        d.trip = temp_sat > 16'(q.trip_thr);
        d.unl = temp_sat > 16'(q.unlock_thr);
        ev = {d.unl & ~q.unl, d.trip & ~q.trip, d.alarm & ~q.alarm};
        d.fsm = ST_IDLE;
      end
      default: begin
        d.fsm = ST_IDLE;
      end
    endcase

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        REG_CTRL: d.amb_sel = reg_wdata[CTRL_AMB_SEL_BIT];
        REG_AMB: d.amb_set = reg_wdata[7:0];
        REG_STARTUP: d.startup = reg_wdata[7:0];
        REG_ALARM: d.alarm_thr = reg_wdata[7:0];
        REG_TRIP: d.trip_thr = reg_wdata[7:0];
        REG_UNLOCK: d.unlock_thr = reg_wdata[7:0];
        REG_RATED_TEMP: d.rated_temp = reg_wdata[7:0];
        REG_BASE_TEMP: d.base_temp = reg_wdata[7:0];
        REG_REF_CURRENT: d.ref_cur = reg_wdata[15:0];
        REG_TAU_STEPS: d.tau_steps = reg_wdata;
        REG_IRQ_STS: w1c = reg_wdata[2:0];
        REG_IRQ_MASK: d.irq_mask = reg_wdata[2:0];
        default: begin
        end
      endcase
    end

    // Register reads, data valid the following cycle only
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: d.rdata = {31'h0, q.amb_sel};
        REG_AMB: d.rdata = {24'h0, q.amb_set};
        REG_STARTUP: d.rdata = {24'h0, q.startup};
        REG_ALARM: d.rdata = {24'h0, q.alarm_thr};
        REG_TRIP: d.rdata = {24'h0, q.trip_thr};
        REG_UNLOCK: d.rdata = {24'h0, q.unlock_thr};
        REG_RATED_TEMP: d.rdata = {24'h0, q.rated_temp};
        REG_BASE_TEMP: d.rdata = {24'h0, q.base_temp};
        REG_REF_CURRENT: d.rdata = {16'h0, q.ref_cur};
        REG_TAU_STEPS: d.rdata = q.tau_steps;
        REG_STATUS: d.rdata = status_word;
        REG_TEMP: d.rdata = {16'h0, q.temp};
        REG_LEVEL: d.rdata = q.level[47:16];
        REG_RMS_A: d.rdata = {16'h0, q.rms[0]};
        REG_RMS_B: d.rdata = {16'h0, q.rms[1]};
        REG_RMS_C: d.rdata = {16'h0, q.rms[2]};
        REG_IRQ_STS: d.rdata = {29'h0, q.irq_sts};
        REG_IRQ_MASK: d.rdata = {29'h0, q.irq_mask};
        default: d.rdata = '0;
      endcase
    end

    // Sticky events, a new event wins over a clear
    d.irq_sts = (q.irq_sts & ~w1c) | ev;
    d.irq = |(d.irq_sts & d.irq_mask);
  end

  // State register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata = q.rdata;
  assign sample_tick = q.tick;
  assign phase_a_current_rms = q.rms[0];
  assign phase_b_current_rms = q.rms[1];
  assign phase_c_current_rms = q.rms[2];
  assign max_current_rms = q.imax;
  assign object_temp = q.temp;
  assign alarm_active = q.alarm;
  assign trip_active = q.trip;
  assign unlock_above = q.unl;
  assign irq = q.irq;

endmodule : ltr_top

// ### tb/ltr_top_checker.sv
`timescale 1ns/1ps
module ltr_top_checker #(
  parameter int SAMPLE_DIV = 64
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Results
  input wire logic sample_tick,
  input wire logic [15:0] phase_a_current_rms,
  input wire logic [15:0] phase_b_current_rms,
  input wire logic [15:0] phase_c_current_rms,
  input wire logic [15:0] max_current_rms,
  input wire logic [15:0] object_temp,
  input wire logic alarm_active,
  input wire logic trip_active,
  input wire logic unlock_above,
  input wire logic irq
);
  logic [31:0] tick_cnt_q;
  logic tick_seen_q;
  logic [15:0] max_ab;
  logic [15:0] max_abc;

  // Cycles since the last sample request
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_q <= 32'h0;
      tick_seen_q <= 1'b0;
    end else begin
      tick_cnt_q <= sample_tick ? 32'h0 : tick_cnt_q + 32'h1;
      tick_seen_q <= tick_seen_q | sample_tick;
    end
  end

  // Largest of the three phase values
  always_comb begin
    max_ab = (phase_a_current_rms > phase_b_current_rms) ? phase_a_current_rms : phase_b_current_rms;
    max_abc = (max_ab > phase_c_current_rms) ? max_ab : phase_c_current_rms;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  property p_tick_pulse; sample_tick |=> !sample_tick; endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick longer than one cycle");
  property p_tick_period; sample_tick && tick_seen_q |-> tick_cnt_q == SAMPLE_DIV - 1; endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick period wrong");
  property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  property p_max_pick; $changed(max_current_rms) |-> max_current_rms == max_abc; endproperty
  a_max_pick: assert property (p_max_pick) else $error("max is not the largest");
  property p_phase_first; $changed(phase_a_current_rms) |-> $stable(max_current_rms); endproperty
  a_phase_first: assert property (p_phase_first) else $error("max moved with phase a");
  property p_temp_after; $changed(object_temp) |-> $stable(max_current_rms); endproperty
  a_temp_after: assert property (p_temp_after) else $error("temp moved with max");
  property p_trip_alarm; trip_active |-> alarm_active; endproperty
  a_trip_alarm: assert property (p_trip_alarm) else $error("trip without alarm");
  property p_alarm_unlock; alarm_active |-> unlock_above; endproperty
  a_alarm_unlock: assert property (p_alarm_unlock) else $error("alarm below unlock");
  property p_irq_fall; $fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without write");
endmodule : ltr_top_checker

bind ltr_top ltr_top_checker #(.SAMPLE_DIV(SAMPLE_DIV)) i_chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sample_tick(sample_tick), .phase_a_current_rms(phase_a_current_rms),
  .phase_b_current_rms(phase_b_current_rms), .phase_c_current_rms(phase_c_current_rms),
  .max_current_rms(max_current_rms), .object_temp(object_temp), .alarm_active(alarm_active),
  .trip_active(trip_active), .unlock_above(unlock_above), .irq(irq)
);

// ### tb/ltr_sampler.sv
`timescale 1ns/1ps
module ltr_sampler (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Request and levels to send
  input wire logic sample_tick,
  input wire logic signed [15:0] lvl_a,
  input wire logic signed [15:0] lvl_b,
  input wire logic signed [15:0] lvl_c,
  // Sample set
  output logic sample_valid,
  output logic signed [15:0] smp_a,
  output logic signed [15:0] smp_b,
  output logic signed [15:0] smp_c
);
  // One sample set per request, idle lines scrambled
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sample_valid <= 1'b0;
      {smp_a, smp_b, smp_c} <= 48'h0;
    end else if (sample_tick) begin
      sample_valid <= 1'b1;
      {smp_a, smp_b, smp_c} <= {lvl_a, lvl_b, lvl_c};
    end else begin
      sample_valid <= 1'b0;
      {smp_a, smp_b, smp_c} <= ~{smp_a, smp_b, smp_c};
    end
  end
endmodule : ltr_sampler

// ### tb/ltr_test.sv
`timescale 1ns/1ps
module ltr_test;
  import ltr_pkg::*;
  localparam int SD = 64;
  localparam int STEP = SD * 4;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic signed [15:0] lvl_a = 16'sh0, lvl_b = 16'sh0, lvl_c = 16'sh0;
  logic signed [15:0] smp_a, smp_b, smp_c;
  logic [7:0] sensor = 8'h0;
  logic sample_tick, sample_valid, alarm, trip, unlock, irq;
  logic [15:0] rms_a, rms_b, rms_c, rms_max, temp;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;

  // Clock
  always #2.5 sys_clk = ~sys_clk;

  ltr_top #(.SAMPLE_DIV(SD), .RMS_WIN(4)) i_dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_tick(sample_tick), .sample_valid(sample_valid),
    .phase_a_current_sample(smp_a), .phase_b_current_sample(smp_b), .phase_c_current_sample(smp_c),
    .ambient_sensor_temp(sensor), .phase_a_current_rms(rms_a), .phase_b_current_rms(rms_b),
    .phase_c_current_rms(rms_c), .max_current_rms(rms_max), .object_temp(temp), .alarm_active(alarm),
    .trip_active(trip), .unlock_above(unlock), .irq(irq)
  );

  ltr_sampler i_smp (
    .sys_clk(sys_clk), .arst_n(arst_n), .sample_tick(sample_tick), .lvl_a(lvl_a), .lvl_b(lvl_b),
    .lvl_c(lvl_c), .sample_valid(sample_valid), .smp_a(smp_a), .smp_b(smp_b), .smp_c(smp_c)
  );

  task automatic end_sim;
    if (fail_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata, exp);
    @(posedge sys_clk);
  endtask : rd_chk

  task automatic steps(input int n);
    repeat (n * STEP + 200) @(posedge sys_clk);
  endtask : steps

  task automatic t_reset_regs;
    logic [7:0] ra[10] = '{REG_CTRL, REG_AMB, REG_STARTUP, REG_ALARM, REG_TRIP, REG_UNLOCK, REG_REF_CURRENT,
      REG_TAU_STEPS, REG_IRQ_MASK, 8'h48};
    logic [31:0] rv[10] = '{32'h0, 32'h19, 32'h0, 32'h50, 32'h64, 32'h3c, 32'h1000, 32'h7530, 32'h0, 32'h0};
    wr(REG_TEMP, 32'hffff);
    wr(8'h48, 32'h5a);
    for (int i = 0; i < 10; i++) begin
      rd_chk(ra[i], rv[i]);
    end
    rd_chk(REG_TEMP, 32'h0);
  endtask : t_reset_regs

  task automatic t_startup;
    wr(REG_STARTUP, 32'h28);
    steps(2);
    chk(32'(temp), 32'd54);
    chk(32'({alarm, trip, unlock}), 32'h0);
    rd_chk(REG_STATUS, 32'h8);
  endtask : t_startup

  task automatic t_rms;
    int v[3] = '{100, -300, 200};
    for (int k = 0; k < 3; k++) begin
      @(posedge sys_clk);
      lvl_a <= 16'(v[k]);
      lvl_b <= 16'(v[(k + 1) % 3]);
      lvl_c <= 16'(v[(k + 2) % 3]);
      steps(2);
      chk(32'(rms_a), 32'(v[k] < 0 ? -v[k] : v[k]));
      chk(32'(rms_b), 32'(v[(k + 1) % 3] < 0 ? -v[(k + 1) % 3] : v[(k + 1) % 3]));
      chk(32'(rms_c), 32'(v[(k + 2) % 3] < 0 ? -v[(k + 2) % 3] : v[(k + 2) % 3]));
      chk(32'(rms_max), 32'd300);
    end
  endtask : t_rms

  task automatic t_heat;
    wr(REG_TAU_STEPS, 32'h2);
    lvl_a <= 16'sd4915;
    lvl_b <= 16'sh0;
    lvl_c <= 16'sh0;
    steps(40);
    chk(32'(temp), 32'd132);
    chk(32'({alarm, trip, unlock}), 32'h7);
    rd_chk(REG_LEVEL, 32'h0001709b);
  endtask : t_heat

  task automatic t_irq;
    rd_chk(REG_IRQ_STS, 32'h7);
    chk(32'(irq), 32'h0);
    wr(REG_IRQ_MASK, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk(32'(irq), 32'h1);
    wr(REG_IRQ_STS, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk(32'(irq), 32'h0);
    rd_chk(REG_IRQ_STS, 32'h6);
  endtask : t_irq

  task automatic t_cool_amb;
    lvl_a <= 16'sh0;
    steps(40);
    chk(32'(temp), 32'd25);
    chk(32'({alarm, trip, unlock}), 32'h0);
    wr(REG_AMB, 32'd30);
    steps(2);
    chk(32'(temp), 32'd30);
    sensor <= 8'd7;
    wr(REG_CTRL, 32'h1);
    steps(2);
    chk(32'(temp), 32'd7);
  endtask : t_cool_amb

  // Hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fail_count++;
      end_sim;
    end
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset_regs();
    t_startup();
    t_rms();
    t_heat();
    t_irq();
    t_cool_amb();
    end_sim();
  end
endmodule : ltr_test
